/* logic/nvs_slave.sv */
`timescale 1ns/1ps
`include "nvs_map.svh"

module nvs_slave import nvs_pkg::*; #(
  parameter int ADDR_W = `NVS_ADDR_W,
  parameter int ADDR_BYTES = `NVS_ADDR_BYTES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic pause_n,
  output logic so,
  output logic so_oe,
  output logic write_enable_latch,
  output logic [1:0] block_protect,
  output logic protect_pin_enable
);
  localparam int DEPTH = 1 << ADDR_W;

  // Synchroniser order: {pause_n, si, sck, cs_n}
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic sck_prev_q;
  logic cs_prev_q;

  nvs_state_t state_q, state_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] out_q, out_d;
  logic [1:0] acnt_q, acnt_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic is_write_q, is_write_d;
  logic is_fast_q, is_fast_d;
  logic wrote_q, wrote_d;
  logic latch_q, latch_d;
  logic [1:0] bp_q, bp_d;
  logic pin_en_q, pin_en_d;
  logic so_q, so_d;
  logic so_oe_q, so_oe_d;

  logic [7:0] mem [DEPTH];
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;

  logic cs_s, sck_s, si_s, pause_s;
  logic sck_rise, sck_fall, cs_rise;
  logic [7:0] nb;
  logic [7:0] status_byte;

  function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a);
    addr_inc = ADDR_W'(a + 1'b1);
  endfunction

  assign cs_s = sync2_q[0];
  assign sck_s = sync2_q[1];
  assign si_s = sync2_q[2];
  assign pause_s = sync2_q[3];
  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;
  assign cs_rise = cs_s & ~cs_prev_q;
  assign nb = {shift_q[6:0], si_s};

  always_comb begin
    status_byte = 8'h00;
    status_byte[`NVS_SR_READY_BIT] = 1'b0;
    status_byte[`NVS_SR_LATCH_BIT] = latch_q;
    status_byte[`NVS_SR_BP_LO_BIT] = bp_q[0];
    status_byte[`NVS_SR_BP_HI_BIT] = bp_q[1];
    status_byte[`NVS_SR_PIN_EN_BIT] = pin_en_q;
  end

  always_comb begin
    state_d = state_q;
    bit_d = bit_q;
    shift_d = shift_q;
    out_d = out_q;
    acnt_d = acnt_q;
    addr_d = addr_q;
    is_write_d = is_write_q;
    is_fast_d = is_fast_q;
    wrote_d = wrote_q;
    latch_d = latch_q;
    bp_d = bp_q;
    pin_en_d = pin_en_q;
    so_d = so_q;
    mem_we = 1'b0;
    mem_wa = addr_q;
    mem_wd = nb;
    if (cs_s) begin
      // Deselected: command ends, next one starts fresh
      state_d = NVS_ST_OPCODE;
      bit_d = 3'h0;
      acnt_d = 2'h0;
      if (cs_rise && wrote_q) begin
        latch_d = 1'b0;
      end
      wrote_d = 1'b0;
    end else if (pause_s) begin
      // Clock edges are disregarded while paused
      if (sck_rise) begin
        shift_d = nb;
        bit_d = 3'(bit_q + 1'b1);
        if (bit_q == 3'h7) begin
          unique case (state_q)
            NVS_ST_OPCODE: begin
              is_write_d = 1'b0;
              is_fast_d = 1'b0;
              acnt_d = 2'h0;
              // Start the address from zero so no old bits leak in
              addr_d = '0;
              state_d = NVS_ST_IGNORE;
              unique case (nb)
                `NVS_OP_LATCH_SET: latch_d = 1'b1;
                `NVS_OP_LATCH_CLEAR: latch_d = 1'b0;
                `NVS_OP_STATUS_READ: begin
                  out_d = status_byte;
                  state_d = NVS_ST_STAT_RD;
                end
                `NVS_OP_STATUS_WRITE: begin
                  state_d = latch_q ? NVS_ST_STAT_WR : NVS_ST_IGNORE;
                end
                `NVS_OP_READ: state_d = NVS_ST_ADDR;
                `NVS_OP_FAST_READ: begin
                  is_fast_d = 1'b1;
                  state_d = NVS_ST_ADDR;
                end
                `NVS_OP_WRITE: begin
                  is_write_d = 1'b1;
                  state_d = latch_q ? NVS_ST_ADDR : NVS_ST_IGNORE;
                end
                default: state_d = NVS_ST_IGNORE;
              endcase
            end
            NVS_ST_ADDR: begin
              addr_d = ADDR_W'({addr_q, nb});
              acnt_d = 2'(acnt_q + 1'b1);
              if (acnt_q == 2'(ADDR_BYTES - 1)) begin
                if (is_write_q) begin
                  state_d = NVS_ST_WDATA;
                end else if (is_fast_q) begin
                  state_d = NVS_ST_DUMMY;
                end else begin
                  out_d = mem[ADDR_W'({addr_q, nb})];
                  addr_d = addr_inc(ADDR_W'({addr_q, nb}));
                  state_d = NVS_ST_RDATA;
                end
              end
            end
            NVS_ST_DUMMY, NVS_ST_RDATA: begin
              out_d = mem[addr_q];
              addr_d = addr_inc(addr_q);
              state_d = NVS_ST_RDATA;
            end
            NVS_ST_WDATA: begin
              mem_we = 1'b1;
              addr_d = addr_inc(addr_q);
              wrote_d = 1'b1;
            end
            NVS_ST_STAT_RD: out_d = status_byte;
            NVS_ST_STAT_WR: begin
              // Stored on the spot, no programming wait
              pin_en_d = nb[`NVS_SR_PIN_EN_BIT];
              bp_d = {nb[`NVS_SR_BP_HI_BIT], nb[`NVS_SR_BP_LO_BIT]};
              wrote_d = 1'b1;
              state_d = NVS_ST_IGNORE;
            end
            NVS_ST_IGNORE: state_d = NVS_ST_IGNORE;
          endcase
        end
      end
      if (sck_fall && (state_q == NVS_ST_RDATA || state_q == NVS_ST_STAT_RD)) begin
        so_d = out_q[7];
        out_d = {out_q[6:0], 1'b0};
      end
    end
    so_oe_d = ~cs_s & pause_s & (state_d == NVS_ST_RDATA || state_d == NVS_ST_STAT_RD);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 4'h9;
      sync2_q <= 4'h9;
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      state_q <= NVS_ST_OPCODE;
      bit_q <= 3'h0;
      shift_q <= 8'h00;
      out_q <= 8'h00;
      acnt_q <= 2'h0;
      addr_q <= '0;
      is_write_q <= 1'b0;
      is_fast_q <= 1'b0;
      wrote_q <= 1'b0;
      latch_q <= `NVS_RST_LATCH;
      bp_q <= `NVS_RST_BP;
      pin_en_q <= `NVS_RST_PIN_EN;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      sync1_q <= {pause_n, si, sck, cs_n};
      sync2_q <= sync1_q;
      sck_prev_q <= sck_s;
      cs_prev_q <= cs_s;
      state_q <= state_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      out_q <= out_d;
      acnt_q <= acnt_d;
      addr_q <= addr_d;
      is_write_q <= is_write_d;
      is_fast_q <= is_fast_d;
      wrote_q <= wrote_d;
      latch_q <= latch_d;
      bp_q <= bp_d;
      pin_en_q <= pin_en_d;
      so_q <= so_d;
      so_oe_q <= so_oe_d;
    end
  end

  // Array write port, no reset on contents
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign so = so_q;
  assign so_oe = so_oe_q;
  assign write_enable_latch = latch_q;
  assign block_protect = bp_q;
  assign protect_pin_enable = pin_en_q;
endmodule

/* logic/nvs_map.svh */
`ifndef NVS_MAP_SVH
`define NVS_MAP_SVH

// Opcodes
`define NVS_OP_LATCH_SET 8'h06
`define NVS_OP_LATCH_CLEAR 8'h04
`define NVS_OP_STATUS_READ 8'h05
`define NVS_OP_STATUS_WRITE 8'h01
`define NVS_OP_READ 8'h03
`define NVS_OP_WRITE 8'h02
`define NVS_OP_FAST_READ 8'h0B

// Status byte field positions
`define NVS_SR_READY_BIT 0
`define NVS_SR_LATCH_BIT 1
`define NVS_SR_BP_LO_BIT 2
`define NVS_SR_BP_HI_BIT 3
`define NVS_SR_PIN_EN_BIT 7

// Reset values
`define NVS_RST_LATCH 1'b0
`define NVS_RST_BP 2'h0
`define NVS_RST_PIN_EN 1'b0

// Defaults of the array geometry
`define NVS_ADDR_W 11
`define NVS_ADDR_BYTES 2

`endif

/* logic/nvs_pkg.sv */
package nvs_pkg;
  typedef enum logic [2:0] {
    NVS_ST_OPCODE = 3'h0,
    NVS_ST_ADDR = 3'h1,
    NVS_ST_DUMMY = 3'h3,
    NVS_ST_RDATA = 3'h2,
    NVS_ST_WDATA = 3'h6,
    NVS_ST_STAT_RD = 3'h7,
    NVS_ST_STAT_WR = 3'h5,
    NVS_ST_IGNORE = 3'h4
  } nvs_state_t;
endpackage

/* test/nvs_slave_monitor.sv */
`timescale 1ns/1ps
module nvs_slave_monitor (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic pause_n,
  input wire logic so,
  input wire logic so_oe,
  input wire logic write_enable_latch,
  input wire logic [1:0] block_protect,
  input wire logic protect_pin_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_oe_deselect: assert property ($rose(cs_n) |-> ##[1:5] !so_oe)
    else $error("so_oe stays after deselect");
  a_oe_idle: assert property (cs_n [*6] |-> !so_oe)
    else $error("so_oe outside frame");
  a_oe_paused: assert property (!pause_n [*6] |-> !so_oe)
    else $error("so_oe during pause");
  a_oe_in_frame: assert property (so_oe |-> !$past(cs_n, 6))
    else $error("so_oe too early");
  a_latch_idle: assert property (cs_n [*7] |-> $stable(write_enable_latch))
    else $error("latch moved while idle");
  a_status_idle: assert property (cs_n [*7] |->
    $stable(block_protect) && $stable(protect_pin_enable))
    else $error("status moved while idle");
  a_latch_set: assert property ($rose(write_enable_latch) |-> !$past(cs_n, 3))
    else $error("latch set outside frame");
  a_status_guard: assert property ($changed({protect_pin_enable, block_protect}) |->
    $past(write_enable_latch))
    else $error("status written without latch");
endmodule
bind nvs_slave nvs_slave_monitor u_nvs_slave_monitor (.sys_clk(sys_clk), .reset_n(reset_n),
  .cs_n(cs_n), .sck(sck), .si(si), .pause_n(pause_n), .so(so), .so_oe(so_oe),
  .write_enable_latch(write_enable_latch), .block_protect(block_protect),
  .protect_pin_enable(protect_pin_enable));

/* test/nvs_host.sv */
`timescale 1ns/1ps
module nvs_host (
  input wire logic sys_clk,
  input wire logic so,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic pause_n
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    pause_n = 1'b1;
  end
  // Mode 0: shift on fall, sample at rise, 4 clocks a phase
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si <= tx[i];
      repeat (4) @(posedge sys_clk);
      sck <= 1'b1;
      rx[i] = so;
      repeat (4) @(posedge sys_clk);
      sck <= 1'b0;
    end
  endtask
  // Before byte pz a byte of clocks is sent while paused
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$], input int pz);
    logic [7:0] b;
    rx = {};
    @(posedge sys_clk);
    cs_n <= 1'b0;
    foreach (tx[k]) begin
      if (k == pz) begin
        repeat (4) @(posedge sys_clk);
        pause_n <= 1'b0;
        xfer(8'hFF, b);
        repeat (4) @(posedge sys_clk);
        pause_n <= 1'b1;
      end
      xfer(tx[k], b);
      rx.push_back(b);
    end
    repeat (4) @(posedge sys_clk);
    cs_n <= 1'b1;
    si <= ~si;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cs_n, sck, si, pause_n, so, so_oe, write_enable_latch, protect_pin_enable;
  logic [1:0] block_protect;
  logic [7:0] r[$];
  logic [7:0] ign[5] = '{8'hAB, 8'h42, 8'hD8, 8'h83, 8'h82};
  int miscompares = 0;
  int check_count = 0;
  logic oe_seen = 1'b0;
  always #10 sys_clk = ~sys_clk;
  // Remembers that the device drove its output at least once
  always @(posedge sys_clk) begin
    if (so_oe === 1'b1) begin
      oe_seen <= 1'b1;
    end
  end
  nvs_slave u_nvs_slave (.sys_clk(sys_clk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck),
    .si(si), .pause_n(pause_n), .so(so), .so_oe(so_oe), .write_enable_latch(write_enable_latch),
    .block_protect(block_protect), .protect_pin_enable(protect_pin_enable));
  nvs_host u_nvs_host (.sys_clk(sys_clk), .so(so), .cs_n(cs_n), .sck(sck), .si(si),
    .pause_n(pause_n));
  function automatic logic [7:0] pins();
    return {protect_pin_enable, 3'h0, block_protect, write_enable_latch, 1'b0};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic go(input logic [7:0] tx[$], input int pz = -1);
    u_nvs_host.frame(tx, r, pz);
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({7'h00, oe_seen}, 8'h00);
    go({8'h05, 8'h00, 8'h00});
    chk(r[1], 8'h00);
    chk(r[2], 8'h00);
    chk({7'h00, oe_seen}, 8'h01);
    chk({7'h00, so_oe}, 8'h00);
    go({8'h06});
    chk(pins(), 8'h02);
    go({8'h04});
    chk(pins(), 8'h00);
    go({8'h01, 8'h8C});
    chk(pins(), 8'h00);
    go({8'h06});
    go({8'h01, 8'h8C});
    chk(pins(), 8'h8C);
    go({8'h05, 8'h00});
    chk(r[1], 8'h8C);
    go({8'h06});
    go({8'h02, 8'h07, 8'hFF, 8'hA5, 8'h3C});
    chk(pins(), 8'h8C);
    go({8'h02, 8'h07, 8'hFF, 8'h11});
    go({8'h06});
    foreach (ign[i]) begin
      go({ign[i], 8'h07, 8'hFF, 8'h55});
      chk(pins(), 8'h8E);
    end
    go({8'h03, 8'h07, 8'hFF, 8'h00, 8'h00}, 3);
    chk(r[3], 8'hA5);
    chk(r[4], 8'h3C);
    chk({7'h00, so_oe}, 8'h00);
    go({8'h0B, 8'h07, 8'hFF, 8'h00, 8'h00, 8'h00});
    chk(r[4], 8'hA5);
    chk(r[5], 8'h3C);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    end_sim();
  end
endmodule
